// [design/adc_out_ctrl.sv]
// Output coding, three-state control and APB status of the sampling converter
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - A low invert select complements every data bit and the inverted MSB output.
// - An unconnected invert select reads as one, giving uncomplemented data.
// - Data outputs are driven while output enable is low and released while it is high.
// - A start pulse during a conversion aborts it and begins a new conversion at once.
// - After such a restart the aborted conversion gives no result and the following one counts as invalid.
// - Uninverted, overflow rises above the all-ones level or at or below the all-zeros level.
// - With inversion active the two overflow conditions swap to the complemented codes.
// - Bipolar coding is offset binary with select high, complementary offset binary low.
module adc_out_ctrl
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Host control pins
  input  wire logic                         start_convert,
  input  wire logic                         output_enable_n,
  input  wire logic                         comp_bits_in,
  input  wire logic                         comp_bits_driven,
  // Converter core sample
  input  wire logic [adc_ctrl_pkg::DATA_W-1:0] core_code,
  input  wire logic                         core_above_top,
  input  wire logic                         core_at_top,
  input  wire logic                         core_at_bottom,
  input  wire logic                         core_below_bottom,
  // Output pins
  output logic                              eoc,
  output logic      [adc_ctrl_pkg::DATA_W-1:0] conversion_data_bits,
  output logic                              msb_n_out,
  output logic                              overflow,
  output logic                              data_oe
);
  import adc_ctrl_pkg::*;

  logic              start_d_ff;
  logic              start_rise;
  logic              soft_start;
  logic              start_req;
  logic              busy;
  logic              done;
  logic              restart;
  logic              comp_eff;
  logic              apb_wr;
  logic              apb_rd;
  logic              addr_ok;
  logic [DATA_W-1:0] samp_ff;
  logic [DATA_W-1:0] nxt_samp;
  logic [3:0]        samp_flags_ff;
  logic [3:0]        nxt_samp_flags;
  logic [DATA_W-1:0] res_ff;
  logic [DATA_W-1:0] nxt_res;
  logic [3:0]        res_flags_ff;
  logic [3:0]        nxt_res_flags;
  logic              inval_pend_ff;
  logic              nxt_inval_pend;
  logic              last_inval_ff;
  logic              nxt_last_inval;
  logic [DATA_W-1:0] dout_ff;
  logic [DATA_W-1:0] nxt_dout;
  logic              msb_n_ff;
  logic              nxt_msb_n;
  logic              ovf_ff;
  logic              nxt_ovf;
  logic              oe_d_ff;
  logic              comp_d_ff;
  logic              quiet_viol_ff;
  logic              nxt_quiet_viol;
  logic [15:0]       conv_cnt_ff;
  logic [15:0]       nxt_conv_cnt;
  logic              ovf_plain;
  logic              ovf_comp;

  // APB strobes and decode
  // Zero-wait slave: every access completes in its first access cycle
  assign apb_wr     = psel && penable && pwrite;
  assign apb_rd     = psel && penable && !pwrite;
  assign pready     = 1'b1;
  assign soft_start = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_SOFT_START];

  always_comb
  begin
    addr_ok = 1'b1;
    prdata  = 32'h0000_0000;
    if (paddr == REG_CTRL)
      prdata = 32'h0000_0000;
    else if (paddr == REG_STATUS)
    begin
      prdata[STAT_BUSY]       = busy;
      prdata[STAT_INVALID]    = last_inval_ff;
      prdata[STAT_QUIET_VIOL] = quiet_viol_ff;
      prdata[STAT_OVERFLOW]   = ovf_ff;
    end
    else if (paddr == REG_RESULT)
      prdata = {14'h0000, ovf_ff, msb_n_ff, dout_ff};
    else if (paddr == REG_CONV_COUNT)
      prdata = {16'h0000, conv_cnt_ff};
    else
      addr_ok = 1'b0;
  end
  assign pslverr = psel && penable && !addr_ok;

  // Start edge from the pin or a software start
  // start_d_ff resets low, the pin's idle level, so no false edge follows reset
  assign start_rise = start_convert && !start_d_ff;
  assign start_req  = start_rise || soft_start;

  conv_timer u_conv_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .start_req (start_req),
    .busy      (busy),
    .done      (done),
    .restart   (restart)
  );

  // Pull-up on the invert select pin
  // A floating select reads as one, so a released pin gives plain coding
  assign comp_eff = comp_bits_driven ? comp_bits_in : 1'b1;

  // Overflow decode for both codings
  // Flags are comparator levels latched with the sample; a complemented
  // word swaps which end of the range counts as over
  assign ovf_plain = res_flags_ff[0] || res_flags_ff[2] || res_flags_ff[3];
  assign ovf_comp  = res_flags_ff[0] || res_flags_ff[1] || res_flags_ff[3];

  // Sample, result and validity next values
  // Aborted samples never reach the result; the restarted one is marked
  always_comb
  begin
    nxt_samp       = samp_ff;
    nxt_samp_flags = samp_flags_ff;
    nxt_res        = res_ff;
    nxt_res_flags  = res_flags_ff;
    nxt_inval_pend = inval_pend_ff;
    nxt_last_inval = last_inval_ff;
    nxt_conv_cnt   = conv_cnt_ff;
    if (start_req)
    begin
      nxt_samp       = core_code;
      nxt_samp_flags = {core_below_bottom, core_at_bottom, core_at_top, core_above_top};
    end
    if (restart)
      nxt_inval_pend = 1'b1;
    if (done)
    begin
      nxt_res        = samp_ff;
      nxt_res_flags  = samp_flags_ff;
      nxt_last_inval = inval_pend_ff;
      nxt_inval_pend = 1'b0;
      nxt_conv_cnt   = conv_cnt_ff + 16'h0001;
    end
  end

  // Presented word, inverted MSB and overflow
  // A select change shows one edge later; the host keeps it still while busy
  always_comb
  begin
    if (comp_eff)
    begin
      nxt_dout  = res_ff;
      nxt_msb_n = ~res_ff[MSB_POS];
      nxt_ovf   = ovf_plain;
    end
    else
    begin
      nxt_dout  = ~res_ff;
      nxt_msb_n = res_ff[MSB_POS];
      nxt_ovf   = ovf_comp;
    end
  end

  // Quiet window monitor, set wins over clear
  // Each pin is compared with its value one edge earlier while busy
  always_comb
  begin
    nxt_quiet_viol = quiet_viol_ff;
    if (apb_wr && (paddr == REG_STATUS) && pwdata[STAT_QUIET_VIOL])
      nxt_quiet_viol = 1'b0;
    if (busy && ((output_enable_n != oe_d_ff) || (comp_eff != comp_d_ff)))
      nxt_quiet_viol = 1'b1;
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_d_ff    <= 1'b0;
      samp_ff       <= DATA_RST;
      samp_flags_ff <= 4'h0;
      res_ff        <= DATA_RST;
      res_flags_ff  <= 4'h0;
      inval_pend_ff <= 1'b0;
      last_inval_ff <= 1'b0;
      dout_ff       <= DATA_RST;
      msb_n_ff      <= 1'b1;
      ovf_ff        <= 1'b0;
      oe_d_ff       <= 1'b1;
      comp_d_ff     <= 1'b1;
      quiet_viol_ff <= 1'b0;
      conv_cnt_ff   <= COUNT_RST;
    end
    else
    begin
      start_d_ff    <= start_convert;
      samp_ff       <= nxt_samp;
      samp_flags_ff <= nxt_samp_flags;
      res_ff        <= nxt_res;
      res_flags_ff  <= nxt_res_flags;
      inval_pend_ff <= nxt_inval_pend;
      last_inval_ff <= nxt_last_inval;
      dout_ff       <= nxt_dout;
      msb_n_ff      <= nxt_msb_n;
      ovf_ff        <= nxt_ovf;
      oe_d_ff       <= output_enable_n;
      comp_d_ff     <= comp_eff;
      quiet_viol_ff <= nxt_quiet_viol;
      conv_cnt_ff   <= nxt_conv_cnt;
    end
  end

  // Pin outputs
  assign eoc                  = busy;
  assign conversion_data_bits = dout_ff;
  assign msb_n_out            = msb_n_ff;
  assign overflow             = ovf_ff;
  assign data_oe              = !output_enable_n;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_oe_follows: assert property (data_oe == !output_enable_n)
    else $error("output drive does not follow enable");
  a_invert_data: assert property (!comp_eff |=> dout_ff == ~$past(res_ff))
    else $error("data not complemented with select low");
  a_invert_msb: assert property (!comp_eff |=> msb_n_out == $past(res_ff[MSB_POS]))
    else $error("inverted msb not complemented with select low");
  a_pullup_plain: assert property (!comp_bits_driven |=> dout_ff == $past(res_ff))
    else $error("open select did not give plain data");
  a_restart_start: assert property (busy && start_rise |=> busy ##0 inval_pend_ff)
    else $error("restart did not begin a marked conversion");
  a_invalid_mark: assert property (done && inval_pend_ff |=> last_inval_ff)
    else $error("conversion after restart not marked invalid");
  a_valid_mark: assert property (done && !inval_pend_ff && !restart |=> !last_inval_ff)
    else $error("clean conversion marked invalid");
  a_ovf_plain: assert property (comp_eff && res_flags_ff[2] |=> overflow)
    else $error("overflow missing at all-zeros level");
  a_ovf_swap: assert property (!comp_eff && res_flags_ff == 4'h4 |=> !overflow)
    else $error("overflow conditions not swapped");
  a_data_at_end: assert property (done |=> res_ff == $past(samp_ff))
    else $error("result not loaded at end of conversion");
  a_ovf_with_data: assert property (done |=> res_flags_ff == $past(samp_flags_ff))
    else $error("overflow not taken with its data word");
  a_quiet_flag: assert property (busy && (output_enable_n != oe_d_ff) |=> quiet_viol_ff)
    else $error("change during conversion not flagged");

  // Plain coding passes the result through
  a_plain_data: assert property (comp_eff |=> dout_ff == $past(res_ff))
    else $error("data not passed through with select high");
  a_plain_msb: assert property (comp_eff |=> msb_n_out == !$past(res_ff[MSB_POS]))
    else $error("inverted msb wrong with select high");

  // Overflow at the top end in each coding
  a_ovf_top_plain: assert property (comp_eff && res_flags_ff == 4'h2 |=> !overflow)
    else $error("overflow raised at all-ones level");
  a_ovf_top_swap: assert property (!comp_eff && res_flags_ff[1] |=> overflow)
    else $error("swapped overflow missing at top level");
  a_ovf_above: assert property (res_flags_ff[0] |=> overflow)
    else $error("overflow missing above full scale");

  // Sequencing, counting and status read-back
  a_soft_start: assert property (soft_start && !busy |=> busy)
    else $error("software start did not begin a conversion");
  a_count_step: assert property (done |=> conv_cnt_ff == $past(conv_cnt_ff) + 16'h0001)
    else $error("completed conversion not counted");
  a_inval_clear: assert property (done |=> !inval_pend_ff)
    else $error("invalid mark carried past its conversion");
  a_status_busy: assert property (apb_rd && paddr == REG_STATUS |-> prdata[STAT_BUSY] == eoc)
    else $error("status busy bit differs from the flag");
  a_result_ovf: assert property (apb_rd && paddr == REG_RESULT |-> prdata[RES_OVERFLOW] == overflow)
    else $error("result word overflow differs from the pin");

  c_plain_conv: cover property (start_rise ##1 busy [*8] ##1 !busy);
  c_restart: cover property (restart ##[1:20] done);
  c_inverted_ovf: cover property (!comp_eff && overflow);
  c_quiet_viol: cover property ($rose(quiet_viol_ff));
  c_result_read: cover property (apb_rd && paddr == REG_RESULT);
endmodule

// [design/adc_ctrl_pkg.sv]
// Shared constants for the converter output and control block
package adc_ctrl_pkg;
  // Data path
  localparam int          DATA_W         = 16;
  localparam int          MSB_POS        = DATA_W - 1;
  // Timing: core conversion time and derived cycle count
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          CONV_TIME_NS   = 400;
  localparam int          CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 4;
  localparam logic [3:0]  CONV_LAST      = 4'(CONV_CYCLES - 1);
  // APB
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_STATUS     = 12'h004;
  localparam logic [11:0] REG_RESULT     = 12'h008;
  localparam logic [11:0] REG_CONV_COUNT = 12'h00C;
  // Control fields
  localparam int          CTRL_SOFT_START = 0;
  // Status fields
  localparam int          STAT_BUSY       = 0;
  localparam int          STAT_INVALID    = 1;
  localparam int          STAT_QUIET_VIOL = 2;
  localparam int          STAT_OVERFLOW   = 3;
  // Result fields
  localparam int          RES_MSB_N       = 16;
  localparam int          RES_OVERFLOW    = 17;
  // Reset values
  localparam logic [15:0] DATA_RST        = 16'h0000;
  localparam logic [15:0] COUNT_RST       = 16'h0000;
  localparam logic [3:0]  CNT_RST         = 4'h0;
  // Sequencer states
  typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_t;
endpackage

// [design/conv_timer.sv]
// Conversion sequencer: busy window, completion and restart detection
`timescale 1ns/10ps
module conv_timer
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request
  input  wire logic start_req,
  // Status
  output logic      busy,
  output logic      done,
  output logic      restart
);
  import adc_ctrl_pkg::*;

  conv_state_t             state_ff;
  conv_state_t             nxt_state;
  logic        [CNT_W-1:0] cnt_ff;
  logic        [CNT_W-1:0] nxt_cnt;

  // Next state of the sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      CONV_IDLE:
      begin
        if (start_req)
        begin
          nxt_state = CONV_BUSY;
          nxt_cnt   = CNT_RST;
        end
      end
      CONV_BUSY:
      begin
        if (start_req)
          nxt_cnt = CNT_RST; // Abort and begin again
        else if (cnt_ff == CONV_LAST)
          nxt_state = CONV_IDLE;
        else
          nxt_cnt = cnt_ff + 4'h1;
      end
      default:
        nxt_state = CONV_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= CONV_IDLE;
      cnt_ff   <= CNT_RST;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Status decode
  assign busy    = (state_ff == CONV_BUSY);
  assign done    = busy && (cnt_ff == CONV_LAST) && !start_req;
  assign restart = busy && start_req;

  a_busy_length: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) ##0 (!start_req)[*8] |=> !busy)
    else $error("conversion lasted longer than its count");
  a_restart_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> busy && cnt_ff == CNT_RST)
    else $error("restart did not begin a new conversion");
endmodule

// [dv/host_model.sv]
// Host logic model driving start, enable and coding pins
`timescale 1ns/10ps
module host_model
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench commands
  input  wire logic go,
  input  wire logic long_pulse,
  input  wire logic sel_req,
  input  wire logic float_req,
  input  wire logic oe_n_req,
  input  wire logic ignore_quiet,
  // Device status
  input  wire logic eoc,
  // Pins toward the device
  output logic      start_convert,
  output logic      output_enable_n,
  output logic      comp_bits_in,
  output logic      comp_bits_driven
);
  logic [3:0] width_ff;
  logic [3:0] nxt_width;
  logic       sel_ff;
  logic       nxt_sel;
  logic       oe_n_ff;
  logic       nxt_oe_n;
  logic       drv_ff;
  logic       nxt_drv;

  // Pulse width and pin settings
  always_comb
  begin
    nxt_width = (width_ff != 4'h0) ? width_ff - 4'h1 : width_ff;
    if (go && width_ff == 4'h0)
      nxt_width = long_pulse ? 4'h8 : 4'h2; // 400 ns or 100 ns wide
    nxt_oe_n = oe_n_ff;
    nxt_drv  = drv_ff;
    nxt_sel  = sel_ff;
    // Pins only move while idle, unless told to break the
    if (!eoc || ignore_quiet)
    begin
      nxt_oe_n = oe_n_req;
      nxt_drv  = !float_req;
      nxt_sel  = sel_req;
    end
    // Released line shows a changing level, not the last one
    if (!nxt_drv)
      nxt_sel = ~sel_ff;
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      width_ff <= 4'h0;
      sel_ff   <= 1'h1;
      oe_n_ff  <= 1'h0;
      drv_ff   <= 1'h1;
    end
    else
    begin
      width_ff <= nxt_width;
      sel_ff   <= nxt_sel;
      oe_n_ff  <= nxt_oe_n;
      drv_ff   <= nxt_drv;
    end
  end

  assign start_convert    = (width_ff != 4'h0);
  assign output_enable_n  = oe_n_ff;
  assign comp_bits_in     = sel_ff;
  assign comp_bits_driven = drv_ff;
endmodule

// [dv/tb.sv]
// Self-checking bench for the converter output and control block
`timescale 1ns/10ps
module tb;
  import adc_ctrl_pkg::*;
  typedef struct packed {
    logic [15:0] code;
    logic [3:0]  flags;
    logic        sel;
    logic        flt;
    logic [15:0] data;
    logic        ovf;
  } row_t;
  row_t        rows [8] = '{
    '{16'h1234, 4'h0, 1'h1, 1'h0, 16'h1234, 1'h0},
    '{16'h1234, 4'h0, 1'h0, 1'h0, 16'hEDCB, 1'h0},
    '{16'hFFFF, 4'h8, 1'h0, 1'h1, 16'hFFFF, 1'h1},
    '{16'hFFFF, 4'h4, 1'h1, 1'h0, 16'hFFFF, 1'h0},
    '{16'hFFFF, 4'h4, 1'h0, 1'h0, 16'h0000, 1'h1},
    '{16'h0000, 4'h2, 1'h1, 1'h0, 16'h0000, 1'h1},
    '{16'h0000, 4'h2, 1'h0, 1'h0, 16'hFFFF, 1'h0},
    '{16'h8000, 4'h1, 1'h0, 1'h0, 16'h7FFF, 1'h1}};
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        go = 1'h0;
  logic        long_pulse = 1'h0;
  logic        sel_req = 1'h1;
  logic        float_req = 1'h0;
  logic        oe_n_req = 1'h0;
  logic        ignore_quiet = 1'h0;
  logic [15:0] core_code = 16'h0000;
  logic [3:0]  core_flags = 4'h0;
  logic        start_convert;
  logic        output_enable_n;
  logic        comp_bits_in;
  logic        comp_bits_driven;
  logic        eoc;
  logic [15:0] conversion_data_bits;
  logic        msb_n_out;
  logic        overflow;
  logic        data_oe;
  logic [31:0] rd;
  logic        err;
  logic [15:0] cnt0;
  row_t        r;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n;

  // Clock generator
  initial
  begin
    forever #25 pclk = ~pclk;
  end

  host_model u_host (.pclk(pclk), .presetn(presetn), .go(go), .long_pulse(long_pulse),
    .sel_req(sel_req), .float_req(float_req), .oe_n_req(oe_n_req), .eoc(eoc),
    .ignore_quiet(ignore_quiet),
    .start_convert(start_convert), .output_enable_n(output_enable_n),
    .comp_bits_in(comp_bits_in), .comp_bits_driven(comp_bits_driven));

  adc_out_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start_convert(start_convert), .output_enable_n(output_enable_n),
    .comp_bits_in(comp_bits_in), .comp_bits_driven(comp_bits_driven),
    .core_code(core_code), .core_above_top(core_flags[3]), .core_at_top(core_flags[2]),
    .core_at_bottom(core_flags[1]), .core_below_bottom(core_flags[0]), .eoc(eoc),
    .conversion_data_bits(conversion_data_bits), .msb_n_out(msb_n_out),
    .overflow(overflow), .data_oe(data_oe));

  // Verdict and end of run
  task test_done;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One comparison
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'h1)
    begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // One APB transfer, waiting for pready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Bounded wait for a busy level
  task wait_eoc(input logic v);
    int k;
    k = 0;
    while (eoc !== v && k < 50)
    begin
      @(posedge pclk);
      k++;
    end
    chk(eoc === v, "busy flag wait");
  endtask

  // Start pulse request
  task pulse;
    @(posedge pclk);
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
  endtask

  // Cycle ceiling
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      $display("ERROR %0t timeout", $time);
      test_done;
    end
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    chk(eoc === 1'h0 && msb_n_out === 1'h1 && overflow === 1'h0, "reset outputs");
    presetn <= 1'h1;
    // Warm-up: three complete conversions, each run until busy falls
    repeat (3)
    begin
      pulse;
      wait_eoc(1'h1);
      wait_eoc(1'h0);
    end
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      @(posedge pclk);
      core_code <= r.code;
      core_flags <= r.flags;
      sel_req <= r.sel;
      float_req <= r.flt;
      oe_n_req <= i[0];
      long_pulse <= i[1];
      repeat (3) @(posedge pclk);
      pulse;
      wait_eoc(1'h1);
      wait_eoc(1'h0);
      repeat (3) @(posedge pclk);
      chk(conversion_data_bits === r.data, "data word");
      chk(msb_n_out === ~r.data[15], "inverted msb");
      chk(overflow === r.ovf, "overflow pin");
      chk(data_oe === ~i[0], "output drive");
      apb(1'h0, REG_RESULT, 32'h0);
      chk(rd[17:0] === {r.ovf, ~r.data[15], r.data}, "result word");
    end
    // Short pulses, plain coding from here on; drive on until the enable change below
    long_pulse <= 1'h0;
    oe_n_req <= 1'h0;
    sel_req <= 1'h1;
    // Restart while converting
    apb(1'h0, REG_CONV_COUNT, 32'h0);
    cnt0 = rd[15:0];
    pulse;
    wait_eoc(1'h1);
    repeat (3) @(posedge pclk);
    pulse;
    n = 0;
    while (eoc === 1'h1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 9, "restart extends busy");
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd[STAT_INVALID] === 1'h1, "invalid flag");
    apb(1'h0, REG_CONV_COUNT, 32'h0);
    chk(rd[15:0] === cnt0 + 16'h0001, "aborted not counted");
    // Soft start and busy length
    apb(1'h1, REG_CTRL, 32'h1);
    wait_eoc(1'h1);
    n = 0;
    while (eoc === 1'h1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n == CONV_CYCLES, "busy length");
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd[STAT_INVALID] === 1'h0, "clean result");
    apb(1'h0, 12'h010, 32'h0);
    chk(err === 1'h1 && rd === 32'h0, "unmapped address");
    // Enable change inside the conversion window
    ignore_quiet <= 1'h1;
    pulse;
    wait_eoc(1'h1);
    oe_n_req <= 1'h1;
    wait_eoc(1'h0);
    ignore_quiet <= 1'h0;
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd[STAT_QUIET_VIOL] === 1'h1, "quiet window flag");
    apb(1'h1, REG_STATUS, 32'h1 << STAT_QUIET_VIOL);
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd[STAT_QUIET_VIOL] === 1'h0, "quiet window clear");
    // Second reset in mid-run
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    chk(eoc === 1'h0 && conversion_data_bits === 16'h0000, "mid-run reset");
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    chk(eoc === 1'h0 && conversion_data_bits === 16'h0000, "after release");
    chk(msb_n_out === 1'h1 && overflow === 1'h0, "flags after release");
    pulse;
    wait_eoc(1'h1);
    wait_eoc(1'h0);
    test_done;
  end
endmodule
